// File: hw/fws_ctrl.v
// Host-side controller that polls a parallel flash for write-operation status
`timescale 1ns/100ps
`include "fws_regs.vh"
module fws_ctrl #(
   parameter AW = 20,
   parameter DW = 8
) (
   // Clock and reset
   input  wire          i_clk,
   input  wire          i_reset_n,
   // User request: start a status check at an address
   input  wire          i_start,
   input  wire [AW-1:0] i_addr,
   input  wire          i_window_chk,
   input  wire          i_abandon,
   // User answer
   output reg           o_busy,
   output reg           o_done,
   output reg  [1:0]    o_result,
   output reg           o_window,
   output reg  [DW-1:0] o_data,
   output reg           o_dev_ready,
   // Flash pins
   output reg  [AW-1:0] o_fl_addr,
   input  wire [DW-1:0] i_fl_dq,
   output reg  [DW-1:0] o_fl_dq,
   output reg           o_fl_dq_oe_n,
   output reg           o_fl_ce_n,
   output reg           o_fl_oe_n,
   output reg           o_fl_we_n,
   input  wire          i_fl_ready_busy_n
);
   localparam [8:0] S_IDLE  = 9'h001;
   localparam [8:0] S_RD1   = 9'h002;
   localparam [8:0] S_RD2   = 9'h004;
   localparam [8:0] S_RD3   = 9'h008;
   localparam [8:0] S_RD4   = 9'h010;
   localparam [8:0] S_WR    = 9'h020;
   localparam [8:0] S_GAP   = 9'h040;
   localparam [8:0] S_FINAL = 9'h080;
   localparam [8:0] S_DONE  = 9'h100;
   localparam integer STROBE_N = `FWS_STROBE_CYC;
   localparam [3:0] STROBE  = STROBE_N[3:0];

   reg  [8:0]    state_q;
   reg  [8:0]    ret_q;
   reg  [3:0]    cnt_q;
   reg           strobe_q;
   reg  [DW-1:0] first_q;
   reg           fail_seen_q;
   wire          rb_s;

   // Ready pin comes from the device, so it is synchronised
   fws_sync #(.W(1)) u_rb (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_async   (i_fl_ready_busy_n),
      .o_sync    (rb_s)
   );

   wire strobe_end = strobe_q && (cnt_q == STROBE);
   // Sample data late in the strobe; the pins are stable by then
   wire [DW-1:0] dq = i_fl_dq;
   wire toggled = first_q[`FWS_BIT_TOGGLE] != dq[`FWS_BIT_TOGGLE];

   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         state_q      <= S_IDLE;
         ret_q        <= S_IDLE;
         cnt_q        <= 4'h0;
         strobe_q     <= 1'b0;
         first_q      <= {DW{1'b0}};
         fail_seen_q  <= 1'b0;
         o_busy       <= 1'b0;
         o_done       <= 1'b0;
         o_result     <= `FWS_RES_OK;
         o_window     <= 1'b0;
         o_data       <= {DW{1'b0}};
         o_dev_ready  <= 1'b0;
         o_fl_addr    <= {AW{1'b0}};
         o_fl_dq      <= {DW{1'b0}};
         o_fl_dq_oe_n <= 1'b1;
         o_fl_ce_n    <= 1'b1;
         o_fl_oe_n    <= 1'b1;
         o_fl_we_n    <= 1'b1;
      end else begin
         o_done      <= 1'b0;
         o_dev_ready <= rb_s;
         if (strobe_q) begin
            cnt_q <= cnt_q + 4'h1;
         end
         if (strobe_end) begin
            // Raising the strobe ends each cycle so the device counts it once
            strobe_q  <= 1'b0;
            o_fl_ce_n <= 1'b1;
            o_fl_oe_n <= 1'b1;
            o_fl_we_n <= 1'b1;
         end
         case (state_q)
            S_IDLE: begin
               o_fl_dq_oe_n <= 1'b1;
               if (i_start) begin
                  o_busy      <= 1'b1;
                  o_fl_addr   <= i_addr;
                  fail_seen_q <= 1'b0;
                  state_q     <= S_RD1;
                  cnt_q       <= 4'h0;
                  strobe_q    <= 1'b1;
                  o_fl_ce_n   <= 1'b0;
                  o_fl_oe_n   <= 1'b0;
               end
            end
            S_RD1, S_RD2, S_RD3, S_RD4: begin
               if (i_abandon) begin
                  // Leaving mid-check forfeits history; next start rereads twice
                  strobe_q  <= 1'b0;
                  o_fl_ce_n <= 1'b1;
                  o_fl_oe_n <= 1'b1;
                  o_busy    <= 1'b0;
                  state_q   <= S_IDLE;
               end else if (strobe_end) begin
                  ret_q   <= state_q;
                  state_q <= S_GAP;
                  if (state_q == S_RD1 || state_q == S_RD3) begin
                     first_q <= dq;
                  end else if (state_q == S_RD2 && !toggled) begin
                     ret_q    <= S_FINAL;
                     o_window <= dq[`FWS_BIT_WINDOW];
                  end else if (state_q == S_RD2 && dq[`FWS_BIT_FAIL]) begin
                     fail_seen_q <= 1'b1;
                     ret_q       <= S_RD2;
                  end else if (state_q == S_RD2) begin
                     // Still running and no failure: compare each read with the one before
                     first_q  <= dq;
                     o_window <= dq[`FWS_BIT_WINDOW];
                     ret_q    <= (i_window_chk && dq[`FWS_BIT_WINDOW]) ? S_DONE : S_RD4;
                     if (i_window_chk && dq[`FWS_BIT_WINDOW]) begin
                        // Added sector command may have come too late
                        o_result <= `FWS_RES_WINDOW;
                     end
                  end else if (state_q == S_RD4) begin
                     first_q <= dq;
                     ret_q   <= S_RD1;
                  end
                  if (state_q == S_RD4 && fail_seen_q && toggled) begin
                     ret_q <= S_WR;
                  end else if (state_q == S_RD4 && fail_seen_q) begin
                     ret_q <= S_FINAL;
                  end
               end
            end
            S_WR: begin
               // Reset command after a timeout failure
               if (!strobe_q) begin
                  o_fl_addr    <= `FWS_ADDR_ANY;
                  o_fl_dq      <= `FWS_CMD_RESET;
                  o_fl_dq_oe_n <= 1'b0;
                  o_fl_ce_n    <= 1'b0;
                  o_fl_we_n    <= 1'b0;
                  strobe_q     <= 1'b1;
                  cnt_q        <= 4'h0;
               end else if (strobe_end) begin
                  o_result <= `FWS_RES_FAIL;
                  ret_q    <= S_DONE;
                  state_q  <= S_GAP;
               end
            end
            S_GAP: begin
               o_fl_dq_oe_n <= 1'b1;
               if (ret_q == S_DONE || ret_q == S_WR) begin
                  state_q <= ret_q;
               end else if (ret_q == S_FINAL) begin
                  state_q <= S_FINAL;
                  strobe_q  <= 1'b1;
                  cnt_q     <= 4'h0;
                  o_fl_ce_n <= 1'b0;
                  o_fl_oe_n <= 1'b0;
               end else begin
                  // Gap over: next read; a fail bit starts a fresh recheck pair
                  state_q   <= (ret_q == S_RD1) ? S_RD2 :
                               (ret_q == S_RD2) ? S_RD3 :
                               (ret_q == S_RD3) ? S_RD4 :
                               (ret_q == S_RD4) ? S_RD2 : S_RD1;
                  strobe_q  <= 1'b1;
                  cnt_q     <= 4'h0;
                  o_fl_ce_n <= 1'b0;
                  o_fl_oe_n <= 1'b0;
               end
            end
            S_FINAL: begin
               // One more read returns array data after completion
               if (strobe_end) begin
                  o_data   <= dq;
                  o_result <= (i_window_chk && o_window) ? `FWS_RES_WINDOW : `FWS_RES_OK;
                  state_q  <= S_DONE;
               end
            end
            S_DONE: begin
               o_busy  <= 1'b0;
               o_done  <= 1'b1;
               state_q <= S_IDLE;
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end
endmodule // fws_ctrl

// File: hw/fws_regs.vh
// Constants for the flash write-status polling controller
`ifndef FWS_REGS_VH
`define FWS_REGS_VH
// Status bit positions on the flash data bus
`define FWS_BIT_POLL      3'h7
`define FWS_BIT_TOGGLE    3'h6
`define FWS_BIT_FAIL      3'h5
`define FWS_BIT_WINDOW    3'h3
`define FWS_BIT_STOGGLE   3'h2
// Reset command byte and command address
`define FWS_CMD_RESET     8'hF0
`define FWS_ADDR_ANY      20'h00000
// Bus timing: strobe width in ns, and cycles counted after the first (the strobe lasts one more), at 50 ns period
`define FWS_CLK_NS        50
`define FWS_STROBE_NS     100
`define FWS_STROBE_CYC    ((`FWS_STROBE_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
// Result codes
`define FWS_RES_OK        2'h0
`define FWS_RES_FAIL      2'h1
`define FWS_RES_WINDOW    2'h2
`endif

// File: hw/fws_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module fws_sync #(
   parameter W = 1
) (
   // Clock and reset
   input  wire         i_clk,
   input  wire         i_reset_n,
   // Raw and filtered level
   input  wire [W-1:0] i_async,
   output reg  [W-1:0] o_sync
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;

   // Output moves only once stages two and three agree
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         s1_q   <= {W{1'b0}};
         s2_q   <= {W{1'b0}};
         s3_q   <= {W{1'b0}};
         o_sync <= {W{1'b0}};
      end else begin
         s1_q <= i_async;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            o_sync <= s3_q;
         end
      end
   end
endmodule // fws_sync

// File: tb/fws_ctrl_properties.sv
// Port-level checks for the flash status polling controller
`timescale 1ns/100ps
module fws_ctrl_properties #(
   parameter AW = 20,
   parameter DW = 8
) (
   input wire          i_clk,
   input wire          i_reset_n,
   input wire          i_start,
   input wire          o_busy,
   input wire          o_done,
   input wire [1:0]    o_result,
   input wire [AW-1:0] o_fl_addr,
   input wire [DW-1:0] o_fl_dq,
   input wire          o_fl_dq_oe_n,
   input wire          o_fl_ce_n,
   input wire          o_fl_oe_n,
   input wire          o_fl_we_n
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   property p_reset_cmd; !o_fl_we_n |-> o_fl_dq == 8'hF0 && !o_fl_dq_oe_n && !o_fl_ce_n && o_fl_oe_n; endproperty
   a_reset_cmd: assert property (p_reset_cmd) else $error("bad write cycle");
   property p_read_cyc; !o_fl_oe_n |-> o_fl_dq_oe_n && !o_fl_ce_n && o_fl_we_n; endproperty
   a_read_cyc: assert property (p_read_cyc) else $error("bus driven in read");
   property p_addr_hold; !o_fl_oe_n && !$past(o_fl_oe_n) |-> $stable(o_fl_addr); endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved in read");
   property p_strobe; $fell(o_fl_oe_n) |-> !o_fl_oe_n[*3] ##1 o_fl_oe_n; endproperty
   a_strobe: assert property (p_strobe) else $error("read strobe width wrong");
   property p_done_pulse; o_done |=> !o_done; endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
   property p_busy_cause; $rose(o_busy) |-> $past(i_start); endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy without start");
   property p_two_reads; $rose(o_busy) |-> !o_done[*8]; endproperty
   a_two_reads: assert property (p_two_reads) else $error("done before double read");
   property p_fail_done; $rose(o_fl_we_n) |-> ##[1:20] (o_done && o_result == 2'h1); endproperty
   a_fail_done: assert property (p_fail_done) else $error("no failure after reset command");
   property p_result_hold; !o_busy && !o_done && !$past(o_busy) |-> $stable(o_result); endproperty
   a_result_hold: assert property (p_result_hold) else $error("result changed while idle");
endmodule // fws_ctrl_properties
bind fws_ctrl fws_ctrl_properties #(.AW(AW), .DW(DW)) fws_ctrl_properties_i (.*);

// File: tb/fws_flash_model.sv
// Behavioural flash device: array byte or write-status byte
`timescale 1ns/100ps
module fws_flash_model (
   input  wire       i_ce_n,
   input  wire       i_oe_n,
   input  wire       i_we_n,
   input  wire [7:0] i_dq,
   output wire [7:0] o_dq,
   output wire       o_ready_busy_n
);
   localparam [7:0] ARRAY = 8'h5A;
   integer left = 0;
   reg     erase = 0, fail = 0, win = 0, tog = 0, stog = 0, susp = 0;
   // A failed operation stays busy until the reset command; suspend frees the pin
   wire       active = (left > 0 && !susp) || fail;
   wire       show = left > 0 || fail;
   wire [7:0] stat = {erase ? susp : ~ARRAY[7], tog, fail, win, stog, 3'h0};
   wire [7:0] cur = show ? stat : ARRAY;
   wire       rd = !i_ce_n && !i_oe_n && i_we_n;
   wire       wr = !i_ce_n && !i_we_n;
   // Released bus shows the inverse so a stale value cannot pass
   assign o_dq = rd ? cur : ~cur;
   assign o_ready_busy_n = active ? 1'b0 : 1'bz;
   // Either strobe rising ends the cycle, so both may delimit a read
   always @(negedge rd) begin
      if (active) tog <= ~tog;
      if (erase && show) stog <= ~stog;
      if (left > 0 && !susp) left <= left - 1;
   end
   always @(negedge wr) begin
      // Once the window has closed only a failure lets the reset command in
      if (i_dq == 8'hF0 && !(win && left > 0 && !fail)) begin
         fail <= 0;
         left <= 0;
         win <= 0;
         susp <= 0;
      end
   end
   // Command sequence is taken as already written: status is valid from here
   task start_op(input integer n, input e, input f, input w);
      begin left = n; erase = e; fail = f; win = w; end
   endtask
   task suspend(input s);
      begin susp = s; end
   endtask
endmodule // fws_flash_model

// File: tb/fws_ctrl_tb_top.sv
// Self-checking bench for the flash status polling controller
`timescale 1ns/100ps
module fws_ctrl_tb_top;
   reg         i_clk = 0, i_reset_n = 0, i_start = 0, i_window_chk = 0, i_abandon = 0;
   reg  [19:0] i_addr = 20'h00010;
   wire        o_busy, o_done, o_window, o_dev_ready, o_fl_dq_oe_n, o_fl_ce_n, o_fl_oe_n, o_fl_we_n;
   wire [1:0]  o_result;
   wire [7:0]  o_data, o_fl_dq, flash_dq;
   wire [19:0] o_fl_addr;
   tri1        ready_busy_n;
   wire [7:0]  bus_dq = !o_fl_dq_oe_n ? o_fl_dq : flash_dq;
   integer     n_errors = 0, compares = 0, cyc = 0;
   fws_ctrl fws_ctrl_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_start(i_start), .i_addr(i_addr),
      .i_window_chk(i_window_chk), .i_abandon(i_abandon), .o_busy(o_busy), .o_done(o_done),
      .o_result(o_result), .o_window(o_window), .o_data(o_data), .o_dev_ready(o_dev_ready),
      .o_fl_addr(o_fl_addr), .i_fl_dq(bus_dq), .o_fl_dq(o_fl_dq), .o_fl_dq_oe_n(o_fl_dq_oe_n),
      .o_fl_ce_n(o_fl_ce_n), .o_fl_oe_n(o_fl_oe_n), .o_fl_we_n(o_fl_we_n), .i_fl_ready_busy_n(ready_busy_n));
   fws_flash_model fws_flash_model_i (.i_ce_n(o_fl_ce_n), .i_oe_n(o_fl_oe_n), .i_we_n(o_fl_we_n),
      .i_dq(bus_dq), .o_dq(flash_dq), .o_ready_busy_n(ready_busy_n));
   initial forever #25 i_clk = ~i_clk;
   task finish_test;
      begin
         $display("errors %0d compares %0d", n_errors, compares);
         if (n_errors == 0 && compares > 0) $display("Testbench passed");
         else $display("Testbench failed");
         $finish;
      end
   endtask
   always @(posedge i_clk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         n_errors = n_errors + 1;
         finish_test;
      end
   end
   task check(input string nm, input [7:0] exp, input [7:0] got);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task run;
      integer k;
      begin
         i_start = 1;
         @(posedge i_clk) #1 i_start = 0;
         for (k = 0; k < 500 && o_done !== 1'b1; k = k + 1) @(posedge i_clk) #1;
         check("done", 8'h01, o_done);
      end
   endtask
   task t_idle;
      begin
         run;
         check("result", 8'h00, o_result);
         check("data", 8'h5A, o_data);
         check("ready", 8'h01, o_dev_ready);
      end
   endtask
   task t_prog(input e);
      begin
         fws_flash_model_i.start_op(5, e, 0, 0);
         repeat (8) @(posedge i_clk) #1;
         check("busy pin", 8'h00, o_dev_ready);
         run;
         check("result", 8'h00, o_result);
         check("data", 8'h5A, o_data);
         repeat (8) @(posedge i_clk) #1;
         check("ready", 8'h01, o_dev_ready);
      end
   endtask
   task t_fail;
      begin
         fws_flash_model_i.start_op(1, 0, 1, 0);
         run;
         check("result", 8'h01, o_result);
         check("fail cleared", 8'h00, fws_flash_model_i.fail);
         run;
         check("restart", 8'h00, o_result);
      end
   endtask
   task t_window;
      begin
         i_window_chk = 1;
         fws_flash_model_i.start_op(4, 1, 0, 1);
         run;
         check("window", 8'h02, o_result);
         check("window bit", 8'h01, o_window);
         i_window_chk = 0;
      end
   endtask
   task t_abandon;
      begin
         fws_flash_model_i.start_op(2, 0, 0, 0);
         i_start = 1;
         @(posedge i_clk) #1 i_start = 0;
         repeat (2) @(posedge i_clk) #1;
         i_abandon = 1;
         @(posedge i_clk) #1 i_abandon = 0;
         check("abandon busy", 8'h00, o_busy);
         run;
         check("abandon data", 8'h5A, o_data);
      end
   endtask
   task t_susp;
      begin
         fws_flash_model_i.start_op(3, 1, 0, 0);
         repeat (8) @(posedge i_clk) #1;
         check("busy pin", 8'h00, o_dev_ready);
         fws_flash_model_i.suspend(1);
         repeat (8) @(posedge i_clk) #1;
         check("suspend ready", 8'h01, o_dev_ready);
         run;
         check("suspend result", 8'h00, o_result);
         check("suspend poll", 8'h01, {7'h00, o_data[7]});
         fws_flash_model_i.suspend(0);
         run;
         check("resume data", 8'h5A, o_data);
      end
   endtask
   initial begin
      repeat (6) @(posedge i_clk);
      #1 i_reset_n = 1;
      t_idle;
      t_prog(0);
      t_prog(1);
      t_fail;
      t_abandon;
      t_susp;
      t_window;
      finish_test;
   end
endmodule // fws_ctrl_tb_top
